// ==== logic/alu_core.sv ====
// 16-bit arithmetic unit with flags, multiplier and divide sequencer
// assumes decode presents both operand sources and holds nothing while busyOut is high
`timescale 1ns/1ns
module alu_core
    import alu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic opValid,
    input wire logic [4:0] opCode,
    input wire logic byteMode,
    input wire logic srcMemA,
    input wire logic srcMemB,
    input wire logic [ALU_W-1:0] regOperandA,
    input wire logic [ALU_W-1:0] memOperandA,
    input wire logic [ALU_W-1:0] regOperandB,
    input wire logic [ALU_W-1:0] memOperandB,
    input wire logic [ALU_LITW-1:0] literal5,
    input wire logic dstMem,
    input wire logic [3:0] dstIdx,
    output logic resValid,
    output logic [ALU_W-1:0] resLow,
    output logic [ALU_W-1:0] resHigh,
    output logic resWide,
    output logic regWrEn,
    output logic memWrEn,
    output logic [3:0] dstIdxOut,
    output logic [4:0] flagWord,
    output logic busyOut
);

    // =========================================================================
    // helper functions
    // add with carry in; returns {carry, half carry, wrap, result}
    function automatic logic [18:0] addCore(input logic [15:0] a, input logic [15:0] b,
                                            input logic cin, input logic bw);
        logic [16:0] s;
        logic [4:0] nib;
        logic c;
        logic ov;
        logic [15:0] r;
        s = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
        nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        if (bw) begin
            r = {8'h00, s[7:0]};
            c = s[8];
            ov = (a[7] == b[7]) && (r[7] != a[7]);
        end else begin
            r = s[15:0];
            c = s[16];
            ov = (a[15] == b[15]) && (r[15] != a[15]);
        end
        return {c, nib[4], ov, r};
    endfunction : addCore

    // keep only the selected width
    function automatic logic [15:0] widthMask(input logic [15:0] v, input logic bw);
        return bw ? {8'h00, v[7:0]} : v;
    endfunction : widthMask

    // =========================================================================
    // state
    alu_state_t state_r; // sequencer state
    alu_state_t state_nxt;
    logic resValid_r; // result strobe
    logic resValid_nxt;
    logic [ALU_W-1:0] resLow_r; // low word or only word
    logic [ALU_W-1:0] resLow_nxt;
    logic [ALU_W-1:0] resHigh_r; // high word of product, remainder
    logic [ALU_W-1:0] resHigh_nxt;
    logic resWide_r; // high word also valid
    logic resWide_nxt;
    logic dstMem_r; // destination latched at accept
    logic dstMem_nxt;
    logic [3:0] dstIdx_r; // destination register index
    logic [3:0] dstIdx_nxt;
    logic [4:0] flag_r; // flag word
    logic [4:0] flag_nxt;
    logic busy_r; // a multiply or divide is in flight
    logic busy_nxt;
    logic mulNarrow_r; // byte product, single word
    logic mulNarrow_nxt;
    logic [ALU_W-1:0] divRem_r; // partial remainder
    logic [ALU_W-1:0] divRem_nxt;
    logic [ALU_W-1:0] divQuo_r; // dividend shifting into quotient
    logic [ALU_W-1:0] divQuo_nxt;
    logic [ALU_W-1:0] divisor_r; // held divisor
    logic [ALU_W-1:0] divisor_nxt;
    logic [4:0] divCnt_r; // steps done
    logic [4:0] divCnt_nxt;

    // combinational helpers
    logic [ALU_W-1:0] opA; // selected first operand
    logic [ALU_W-1:0] opB; // selected second operand
    logic accept; // request taken this cycle
    logic mulStart; // multiplier launch
    logic signed [ALU_MW-1:0] mulX; // extended multiplier inputs
    logic signed [ALU_MW-1:0] mulY;
    logic signed [2*ALU_MW-1:0] mulProd; // registered product
    logic mulDone; // product ready

    // =========================================================================
    // operand select and request acceptance
    // operand source mux
    assign opA = srcMemA ? memOperandA : regOperandA;
    assign opB = srcMemB ? memOperandB : regOperandB;
    // requests during a multiply or divide are dropped, decode must watch busyOut
    assign accept = opValid && (state_r == ST_IDLE);

    // =========================================================================
    // multiplier operand extension
    always_comb begin
        mulStart = 1'b0;
        mulX = '0;
        mulY = '0;
        if (accept) begin
            case (opCode)
                OP_MUL_SS: begin
                    mulStart = 1'b1;
                    mulX = {opA[15], opA};
                    mulY = {opB[15], opB};
                end
                OP_MUL_UU: begin
                    mulStart = 1'b1;
                    mulX = {1'b0, opA};
                    mulY = {1'b0, opB};
                end
                OP_MUL_US: begin
                    mulStart = 1'b1;
                    mulX = {1'b0, opA};
                    mulY = {opB[15], opB};
                end
                OP_MUL_SLIT: begin
                    mulStart = 1'b1;
                    mulX = {opA[15], opA};
                    mulY = {12'h000, literal5};
                end
                OP_MUL_ULIT: begin
                    mulStart = 1'b1;
                    mulX = {1'b0, opA};
                    mulY = {12'h000, literal5};
                end
                OP_MUL_BB: begin
                    mulStart = 1'b1;
                    mulX = {9'h000, opA[7:0]};
                    mulY = {9'h000, opB[7:0]};
                end
                default: begin
                    mulStart = 1'b0;
                end
            endcase
        end
    end

    alu_mult17 u_mult (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(mulStart),
        .opX(mulX),
        .opY(mulY),
        .product(mulProd),
        .done(mulDone)
    );

    // =========================================================================
    // next-state logic for the whole datapath
    always_comb begin
        logic [18:0] sum;
        logic [15:0] r;
        logic [16:0] trial;
        sum = '0;
        r = '0;
        trial = '0;
        state_nxt = state_r;
        resValid_nxt = 1'b0;
        resLow_nxt = resLow_r;
        resHigh_nxt = resHigh_r;
        resWide_nxt = resWide_r;
        dstMem_nxt = dstMem_r;
        dstIdx_nxt = dstIdx_r;
        flag_nxt = flag_r;
        mulNarrow_nxt = mulNarrow_r;
        divRem_nxt = divRem_r;
        divQuo_nxt = divQuo_r;
        divisor_nxt = divisor_r;
        divCnt_nxt = divCnt_r;
        case (state_r)
            ST_IDLE: begin
                if (accept) begin
                    dstMem_nxt = dstMem;
                    dstIdx_nxt = dstIdx;
                    case (opCode)
                        OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: begin
                            if (opCode == OP_ADD || opCode == OP_ADDC) begin
                                sum = addCore(widthMask(opA, byteMode), widthMask(opB, byteMode),
                                              (opCode == OP_ADDC) ? flag_r[FLG_C] : 1'b0, byteMode);
                            end else begin
                                sum = addCore(widthMask(opA, byteMode), widthMask(~opB, byteMode),
                                              (opCode == OP_SUBB) ? flag_r[FLG_C] : 1'b1, byteMode);
                            end
                            r = sum[15:0];
                            flag_nxt[FLG_C] = sum[18];
                            flag_nxt[FLG_HC] = sum[17];
                            flag_nxt[FLG_WRAP] = sum[16];
                        end
                        OP_AND: r = widthMask(opA & opB, byteMode);
                        OP_IOR: r = widthMask(opA | opB, byteMode);
                        OP_XOR: r = widthMask(opA ^ opB, byteMode);
                        OP_SHL: begin
                            r = widthMask({opA[14:0], 1'b0}, byteMode);
                            flag_nxt[FLG_C] = byteMode ? opA[7] : opA[15];
                        end
                        OP_LSR: begin
                            r = byteMode ? {9'h000, opA[7:1]} : {1'b0, opA[15:1]};
                            flag_nxt[FLG_C] = opA[0];
                        end
                        OP_ASR: begin
                            r = byteMode ? {8'h00, opA[7], opA[7:1]} : {opA[15], opA[15:1]};
                            flag_nxt[FLG_C] = opA[0];
                        end
                        OP_DIV_U: begin
                            divRem_nxt = '0;
                            divQuo_nxt = opA;
                            divisor_nxt = opB;
                            divCnt_nxt = '0;
                            state_nxt = ST_DIV;
                        end
                        OP_MUL_SS, OP_MUL_UU, OP_MUL_US, OP_MUL_SLIT, OP_MUL_ULIT, OP_MUL_BB: begin
                            mulNarrow_nxt = (opCode == OP_MUL_BB);
                            state_nxt = ST_MULW;
                        end
                        default: begin
                            r = '0;
                        end
                    endcase
                    // plain ops answer next cycle; unknown opcodes give nothing
                    if (opCode <= OP_ASR) begin
                        resValid_nxt = 1'b1;
                        resLow_nxt = r;
                        resHigh_nxt = '0;
                        resWide_nxt = 1'b0;
                        flag_nxt[FLG_Z] = byteMode ? (r[7:0] == 8'h00) : (r == 16'h0000);
                        flag_nxt[FLG_N] = byteMode ? r[7] : r[15];
                    end
                end
            end
            ST_MULW: begin
                if (mulDone) begin
                    resValid_nxt = 1'b1;
                    resLow_nxt = mulProd[15:0];
                    resHigh_nxt = mulNarrow_r ? 16'h0000 : mulProd[31:16];
                    resWide_nxt = !mulNarrow_r;
                    state_nxt = ST_IDLE;
                end
            end
            ST_DIV: begin
                // one restoring step per cycle; divide by zero gives an all-ones quotient and the dividend as remainder
                trial = {divRem_r, divQuo_r[15]};
                if (trial >= {1'b0, divisor_r}) begin
                    divRem_nxt = 16'(trial - {1'b0, divisor_r});
                    divQuo_nxt = {divQuo_r[14:0], 1'b1};
                end else begin
                    divRem_nxt = trial[15:0];
                    divQuo_nxt = {divQuo_r[14:0], 1'b0};
                end
                divCnt_nxt = divCnt_r + 5'h01;
                if (divCnt_r == 5'(ALU_DIV_STEPS - 1)) begin
                    resValid_nxt = 1'b1;
                    resLow_nxt = divQuo_nxt;
                    resHigh_nxt = divRem_nxt;
                    resWide_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        busy_nxt = (state_nxt != ST_IDLE);
    end

    // =========================================================================
    // registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            resValid_r <= 1'b0;
            resLow_r <= '0;
            resHigh_r <= '0;
            resWide_r <= 1'b0;
            dstMem_r <= 1'b0;
            dstIdx_r <= '0;
            flag_r <= ALU_FLAG_RST;
            busy_r <= 1'b0;
            mulNarrow_r <= 1'b0;
            divRem_r <= '0;
            divQuo_r <= '0;
            divisor_r <= '0;
            divCnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            resValid_r <= resValid_nxt;
            resLow_r <= resLow_nxt;
            resHigh_r <= resHigh_nxt;
            resWide_r <= resWide_nxt;
            dstMem_r <= dstMem_nxt;
            dstIdx_r <= dstIdx_nxt;
            flag_r <= flag_nxt;
            busy_r <= busy_nxt;
            mulNarrow_r <= mulNarrow_nxt;
            divRem_r <= divRem_nxt;
            divQuo_r <= divQuo_nxt;
            divisor_r <= divisor_nxt;
            divCnt_r <= divCnt_nxt;
        end
    end

    // outputs straight from flops; write enables gate with destination
    logic regWrEn_r;
    logic memWrEn_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            regWrEn_r <= 1'b0;
            memWrEn_r <= 1'b0;
        end else begin
            regWrEn_r <= resValid_nxt && !dstMem_nxt;
            memWrEn_r <= resValid_nxt && dstMem_nxt;
        end
    end

    assign resValid = resValid_r;
    assign resLow = resLow_r;
    assign resHigh = resHigh_r;
    assign resWide = resWide_r;
    assign regWrEn = regWrEn_r;
    assign memWrEn = memWrEn_r;
    assign dstIdxOut = dstIdx_r;
    assign flagWord = flag_r;
    assign busyOut = busy_r;

    // =========================================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_add_word_sum: assert property (accept && opCode == OP_ADD && !byteMode |=>
        resValid_r && resLow_r == 16'($past(opA) + $past(opB))) else $error("word add result wrong");
    a_zero_flag_set: assert property (accept && opCode == OP_XOR |=>
        flag_r[FLG_Z] == (widthMask(resLow_r, $past(byteMode)) == 16'h0000)) else $error("zero flag wrong");
    a_sub_no_borrow: assert property (accept && opCode == OP_SUB && !byteMode |=>
        flag_r[FLG_C] == ($past(opA) >= $past(opB))) else $error("subtract carry wrong");
    a_byte_upper_zero: assert property (accept && byteMode && opCode <= OP_ASR |=>
        resLow_r[15:8] == 8'h00) else $error("byte result upper bits set");
    a_mem_operand_used: assert property (accept && srcMemA && opCode == OP_AND && !byteMode |=>
        resLow_r == ($past(memOperandA) & $past(opB))) else $error("memory operand not used");
    a_one_dest: assert property (resValid_r |-> regWrEn_r != memWrEn_r)
        else $error("write target not exclusive");
    a_mul_signed_wide: assert property (accept && opCode == OP_MUL_SS |-> ##2 resValid_r && resWide_r &&
        {resHigh_r, resLow_r} == 32'($signed($past(opA, 2)) * $signed($past(opB, 2))))
        else $error("signed product wrong");
    a_mul_literal: assert property (accept && opCode == OP_MUL_ULIT |-> ##2
        {resHigh_r, resLow_r} == 32'($past(opA, 2)) * 32'($past(literal5, 2))) else $error("literal product wrong");
    a_mul_byte: assert property (accept && opCode == OP_MUL_BB |-> ##2 resValid_r && !resWide_r &&
        resLow_r == 16'($past(opA[7:0], 2)) * 16'($past(opB[7:0], 2))) else $error("byte product wrong");
    a_div_latency: assert property (accept && opCode == OP_DIV_U |=> busy_r [*8] ##9
        (resValid_r && !busy_r)) else $error("divide did not finish in 17 cycles");

endmodule : alu_core

// ==== logic/alu_mult17.sv ====
// registered 17 x 17 signed multiplier
// assumes the caller extends operands and waits one cycle for the product
`timescale 1ns/1ns
module alu_mult17
    import alu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic signed [ALU_MW-1:0] opX,
    input wire logic signed [ALU_MW-1:0] opY,
    output logic signed [2*ALU_MW-1:0] product,
    output logic done
);

    logic signed [2*ALU_MW-1:0] prod_r; // product register
    logic signed [2*ALU_MW-1:0] prod_nxt;
    logic done_r; // product valid one cycle after start
    logic done_nxt;

    // =========================================================================
    // next product
    always_comb begin
        prod_nxt = opX * opY;
        done_nxt = start;
    end

    // registers; product and valid both cleared by reset so nothing unknown leaks out
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prod_r <= '0;
            done_r <= 1'b0;
        end else begin
            prod_r <= prod_nxt;
            done_r <= done_nxt;
        end
    end

    assign product = prod_r;
    assign done = done_r;

endmodule : alu_mult17

// ==== logic/alu_pkg.sv ====
// shared constants and types for the 16-bit arithmetic unit
// assumes one clock domain and a decode stage that supplies one opcode per request
package alu_pkg;

    // =========================================================================
    // datapath widths
    localparam int ALU_W = 16;        // word width
    localparam int ALU_BW = 8;        // byte width
    localparam int ALU_MW = 17;       // multiplier input width, one extension bit
    localparam int ALU_LITW = 5;      // literal width for literal multiply
    localparam int ALU_DIV_STEPS = 16; // one quotient bit per step

    // =========================================================================
    // flag word bit positions
    localparam int FLG_C = 0;         // carry, inverted borrow on subtract
    localparam int FLG_Z = 1;         // zero
    localparam int FLG_WRAP = 2;      // signed wrap bit
    localparam int FLG_N = 3;         // negative
    localparam int FLG_HC = 4;        // half carry bit, inverted nibble borrow on subtract
    localparam logic [4:0] ALU_FLAG_RST = 5'h00; // flag word after reset

    // =========================================================================
    // opcodes
    typedef enum logic [4:0] {
        OP_ADD = 5'h00,
        OP_ADDC = 5'h01,
        OP_SUB = 5'h02,
        OP_SUBB = 5'h03,
        OP_AND = 5'h04,
        OP_IOR = 5'h05,
        OP_XOR = 5'h06,
        OP_SHL = 5'h07,
        OP_LSR = 5'h08,
        OP_ASR = 5'h09,
        OP_MUL_SS = 5'h0a,
        OP_MUL_UU = 5'h0b,
        OP_MUL_US = 5'h0c,
        OP_MUL_SLIT = 5'h0d,
        OP_MUL_ULIT = 5'h0e,
        OP_MUL_BB = 5'h0f,
        OP_DIV_U = 5'h10
    } alu_op_t;

    // =========================================================================
    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_MULW = 3'h2,
        ST_DIV = 3'h4
    } alu_state_t;

endpackage : alu_pkg

// ==== sim/alu_far_model.sv ====
// far-side model: general register array and one data memory word
// assumes the unit's write strobes are one-cycle pulses on ref_clk
`timescale 1ns/1ns
module alu_far_model
    import alu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] rdIdx,
    output logic [ALU_W-1:0] rdData,
    input wire logic regWrEn,
    input wire logic memWrEn,
    input wire logic [3:0] dstIdxOut,
    input wire logic [ALU_W-1:0] resLow,
    input wire logic [ALU_W-1:0] resHigh,
    input wire logic resWide
);
    // =========================================================================
    // storage
    logic [ALU_W-1:0] regs [16]; // word i resets to 1111h times i, known operands
    logic [ALU_W-1:0] memWord; // last word stored to memory
    assign rdData = regs[rdIdx];
    // write-back, a wide product fills two registers
    always @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                regs[i] <= 16'h1111 * 16'(i);
            end
            memWord <= 16'h0000;
        end else begin
            if (regWrEn) regs[dstIdxOut] <= resLow;
            if (regWrEn && resWide) regs[dstIdxOut + 4'h1] <= resHigh;
            if (memWrEn) memWord <= resLow;
        end
    end
endmodule : alu_far_model

// ==== sim/cpu_alu_with_multiplier_bench.sv ====
// self-checking bench for the arithmetic unit, one request at a time
// assumes the far model supplies register operands and takes write-backs
`timescale 1ns/1ns
module cpu_alu_with_multiplier_bench
    import alu_pkg::*;
;
    // =========================================================================
    // stimulus and observed signals
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic opValid = 1'b0;
    logic byteMode = 1'b0;
    logic sw = 1'b0; // swap: operand a from register, b from memory
    logic dstMem = 1'b0;
    logic [4:0] opCode = 5'h00;
    logic [4:0] literal5 = 5'h00;
    logic [15:0] opA = 16'h0000;
    logic [3:0] rdIdx = 4'h0;
    logic [3:0] dstIdx = 4'h0;
    logic [15:0] rdData, resLow, resHigh;
    logic resValid, resWide, regWrEn, memWrEn, busyOut;
    logic [3:0] dstIdxOut;
    logic [4:0] flagWord;
    int failures = 0;
    int total_checks = 0;
    int k = 0; // request count, picks destination
    always #50 ref_clk = ~ref_clk;
    alu_core DUT (.ref_clk(ref_clk), .rst(rst), .opValid(opValid), .opCode(opCode), .byteMode(byteMode),
        .srcMemA(~sw), .srcMemB(sw), .regOperandA(rdData), .memOperandA(opA), .regOperandB(rdData),
        .memOperandB(opA), .literal5(literal5), .dstMem(dstMem), .dstIdx(dstIdx), .resValid(resValid),
        .resLow(resLow), .resHigh(resHigh), .resWide(resWide), .regWrEn(regWrEn), .memWrEn(memWrEn),
        .dstIdxOut(dstIdxOut), .flagWord(flagWord), .busyOut(busyOut));
    alu_far_model FAR (.ref_clk(ref_clk), .rst(rst), .rdIdx(rdIdx), .rdData(rdData), .regWrEn(regWrEn),
        .memWrEn(memWrEn), .dstIdxOut(dstIdxOut), .resLow(resLow), .resHigh(resHigh), .resWide(resWide));
    // =========================================================================
    // shared tasks
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    // one request, wait for its answer, compare outputs and write-back
    task run(input int op, input int bm, input logic [15:0] a, input int rb, input int lit,
        input logic [31:0] ex, input int wd, input int fl, input int lat, input int drop = 0, input int swap = 0);
        int n;
        logic [3:0] idx;
        logic dm;
        idx = 4'h4 + 4'(k % 8); // keep clear of operand registers 0, 1, 2, 15
        dm = k[0];
        k++;
        @(posedge ref_clk);
        opValid <= 1'b1;
        opCode <= op[4:0];
        byteMode <= bm[0];
        opA <= a;
        rdIdx <= rb[3:0];
        literal5 <= lit[4:0];
        sw <= swap[0];
        dstMem <= dm;
        dstIdx <= idx;
        // request taken at this edge; an alu answer stands right after it
        @(posedge ref_clk);
        opValid <= 1'b0;
        #1;
        check("busy", busyOut, lat > 1);
        n = 1;
        while (resValid !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            n++;
            // a stray request in mid-divide must be dropped
            opValid <= drop != 0 && n == 4;
            #1;
        end
        check("latency", n, lat);
        check("result", {resHigh, resLow}, ex);
        check("wide", resWide, wd);
        check("flags", flagWord, fl);
        check("write", {memWrEn, regWrEn}, {dm, ~dm});
        check("index", dstIdxOut, idx);
        @(posedge ref_clk);
        #1;
        if (dm) check("memory", FAR.memWord, ex[15:0]);
        else check("register", FAR.regs[idx], ex[15:0]);
        if (!dm && wd != 0) check("upper", FAR.regs[idx + 4'h1], ex[31:16]);
        if (drop != 0) begin
            n = 0;
            repeat (20) begin
                @(posedge ref_clk);
                #1;
                if (resValid === 1'b1) n++;
            end
            check("dropped", n, 0);
        end
    endtask : run
    // =========================================================================
    // watchdog, about twenty-five times the expected run
    initial begin
        #300000;
        failures++;
        complete_run();
    end
    // =========================================================================
    // main sequence; flags chain from one row to the next
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        check("reset", {busyOut, resValid, flagWord}, 7'h00);
        run(OP_ADD, 0, 16'h7fff, 1, 0, 32'h9110, 0, 5'h1c, 1, 0, 1);
        run(OP_SUB, 0, 16'h0000, 1, 0, 32'heeef, 0, 5'h08, 1);
        run(OP_ADD, 1, 16'h00ff, 1, 0, 32'h0010, 0, 5'h11, 1);
        run(OP_ADDC, 0, 16'h0001, 1, 0, 32'h1113, 0, 5'h00, 1);
        run(OP_SUBB, 0, 16'h0005, 1, 0, 32'heef3, 0, 5'h18, 1);
        run(OP_SUB, 1, 16'h0010, 1, 0, 32'h00ff, 0, 5'h08, 1);
        run(OP_AND, 0, 16'hf0f0, 1, 0, 32'h1010, 0, 5'h00, 1);
        run(OP_XOR, 0, 16'hffff, 15, 0, 32'h0000, 0, 5'h02, 1);
        run(OP_IOR, 0, 16'h8000, 0, 0, 32'h8000, 0, 5'h08, 1);
        run(OP_SHL, 0, 16'h8001, 0, 0, 32'h0002, 0, 5'h01, 1);
        run(OP_LSR, 0, 16'h0001, 0, 0, 32'h0000, 0, 5'h03, 1);
        run(OP_ASR, 0, 16'h8000, 0, 0, 32'hc000, 0, 5'h08, 1);
        run(OP_MUL_SS, 0, 16'hffff, 15, 0, 32'h00000001, 1, 5'h08, 2);
        run(OP_MUL_UU, 0, 16'hffff, 15, 0, 32'hfffe0001, 1, 5'h08, 2);
        run(OP_MUL_US, 0, 16'hffff, 15, 0, 32'hffff0001, 1, 5'h08, 2);
        run(OP_MUL_SLIT, 0, 16'hffff, 0, 31, 32'hffffffe1, 1, 5'h08, 2);
        run(OP_MUL_ULIT, 0, 16'hffff, 0, 31, 32'h001effe1, 1, 5'h08, 2);
        run(OP_MUL_BB, 0, 16'h00ff, 15, 0, 32'h0000fe01, 0, 5'h08, 2);
        run(OP_DIV_U, 0, 16'hffff, 2, 0, 32'h11110007, 1, 5'h08, 17);
        run(OP_DIV_U, 0, 16'h1234, 0, 0, 32'h1234ffff, 1, 5'h08, 17, 1);
        complete_run();
    end
endmodule : cpu_alu_with_multiplier_bench
